/* File: design/nsc_pkg.sv */
// Package for the NAND status/reset/ID host controller.
// Assumes an asynchronous 8-bit multiplexed NAND bus and an APB command port.
package nsc_pkg;
    // APB register offsets
    localparam logic [7:0] NSC_CTRL_OFF    = 8'h00;
    localparam logic [7:0] NSC_ADDR_OFF    = 8'h04;
    localparam logic [7:0] NSC_STAT_OFF    = 8'h08;
    localparam logic [7:0] NSC_RDATA_OFF   = 8'h0C;
    localparam logic [7:0] NSC_ID_LO_OFF   = 8'h10;
    localparam logic [7:0] NSC_ID_HI_OFF   = 8'h14;
    // CTRL fields: start bit 8, op code bits 3:0, address-cycle count bits 6:4
    localparam int NSC_CTRL_GO_BIT  = 8;
    localparam int NSC_CTRL_OP_LSB  = 0;
    localparam int NSC_CTRL_NA_LSB  = 4;
    // Host operation codes
    localparam logic [3:0] NSC_OP_RESET   = 4'h0;
    localparam logic [3:0] NSC_OP_STATUS  = 4'h1;
    localparam logic [3:0] NSC_OP_STAT_EN = 4'h2;
    localparam logic [3:0] NSC_OP_READ_ID = 4'h3;
    localparam logic [3:0] NSC_OP_RD_MODE = 4'h4;
    localparam logic [3:0] NSC_OP_CB_READ = 4'h5;
    localparam logic [3:0] NSC_OP_CB_SPEC = 4'h6;
    // Device command codes
    localparam logic [7:0] NSC_CMD_READ    = 8'h00;
    localparam logic [7:0] NSC_CMD_CB_CONF = 8'h35;
    localparam logic [7:0] NSC_CMD_CB_SPEC = 8'h36;
    localparam logic [7:0] NSC_CMD_STATUS  = 8'h70;
    localparam logic [7:0] NSC_CMD_STAT_EN = 8'h78;
    localparam logic [7:0] NSC_CMD_READ_ID = 8'h90;
    localparam logic [7:0] NSC_CMD_RESET   = 8'hFF;
    localparam logic [7:0] NSC_ID_ADDR     = 8'h00;
    // Status bits of the device's operation_status byte
    localparam int NSC_ST_FAIL  = 0;
    localparam int NSC_ST_OTP   = 3;
    localparam int NSC_ST_ECC   = 4;
    localparam int NSC_ST_ARDY  = 5;
    localparam int NSC_ST_RDY   = 6;
    localparam int NSC_ST_NWP   = 7;
    localparam logic [7:0] NSC_OPST_RST = 8'hE0;
    // Pin timing
    localparam int NSC_CLK_MHZ   = 50;
    localparam int NSC_T_PULSE_NS = 40;
    localparam int NSC_PULSE_CYC  = (NSC_T_PULSE_NS * NSC_CLK_MHZ + 999) / 1000;
    localparam int NSC_ID_BYTES   = 5;
    localparam int NSC_ADDR_MAX   = 5;
    typedef enum logic [2:0] {NSC_IDLE, NSC_CMD, NSC_ADR, NSC_CMD2, NSC_WAIT, NSC_RD, NSC_DONE} nsc_state_t;
endpackage

/* File: design/nsc_idmem.sv */
// Small register memory that keeps the identification bytes read back.
// Assumes one writer and one reader on the same clock.
`timescale 1ns/100ps
module nsc_idmem
    import nsc_pkg::*;
#(
    parameter int DEPTH = 8
) (
    // Clock and reset
    input  wire logic       i_clock,
    input  wire logic       i_sys_rst,
    // Write side
    input  wire logic       i_we,
    input  wire logic [2:0] i_waddr,
    input  wire logic [7:0] i_wdata,
    // Read side
    input  wire logic [2:0] i_raddr,
    output logic      [7:0] o_rdata
);
    logic [7:0] mem_q [DEPTH];
    logic [7:0] rdata_q;

    always_ff @(posedge i_clock) begin
        if (i_we) begin
            mem_q[i_waddr] <= i_wdata;
        end
        if (i_sys_rst) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= mem_q[i_raddr];
        end
    end
    assign o_rdata = rdata_q;
endmodule

/* File: design/nsc_host.sv */
// Host controller issuing reset, status, ID and copy-back read commands to a NAND.
// Assumes an APB master for orders and an asynchronous NAND on its pins.
//
// The address map and the APB register port were chosen for this implementation.
`timescale 1ns/100ps
// Operation
// - 36h confirm only after ECC errors on source page; host sends it whenever NSC_OP_CB_SPEC is ordered.
// - Status mode persists; host issues 00h before resuming data output.
// - Shared chip enable with several dies uses enhanced status, not 70h.
// - Enhanced status sends die and plane address; status of that plane returns.
// - Host sends reset first after power-on on every chip enable.
// - ID command plus one zero address; five bytes read; ID mode persists.
// - Dummy 00h before status read after identification; host refuses 70h until any operation other than NSC_OP_READ_ID or NSC_OP_STATUS is ordered.
module nsc_host
    import nsc_pkg::*;
(
    // Clock and reset
    input  wire logic        i_clock,
    input  wire logic        i_sys_rst,
    // APB slave
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [7:0]  i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic      [31:0] o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    // NAND pins
    output logic             o_nand_ce_n,
    output logic             o_nand_cle,
    output logic             o_nand_ale,
    output logic             o_nand_we_n,
    output logic             o_nand_re_n,
    output logic      [7:0]  o_nand_io,
    output logic             o_nand_io_oe,
    input  wire logic [7:0]  i_nand_io,
    input  wire logic        i_nand_rb_n
);
    nsc_state_t  st_q, st_d;
    logic [3:0]  op_q, op_d;
    logic [2:0]  na_q, na_d, ai_q, ai_d;
    logic [39:0] addr_q, addr_d;
    logic [2:0]  rc_q, rc_d;
    logic [7:0]  ph_q, ph_d;
    logic        hi_q, hi_d;
    logic        rstd_q, rstd_d, idm_q, idm_d, busy_q, busy_d;
    logic [7:0]  opst_q, opst_d;
    logic        ce_n_q, ce_n_d, cle_q, cle_d, ale_q, ale_d, we_n_q, we_n_d, re_n_q, re_n_d;
    logic [7:0]  io_q, io_d;
    logic        oe_q, oe_d;
    logic [31:0] prdata_q, prdata_d;
    logic        pready_q, pready_d, perr_q, perr_d;
    logic [7:0]  io_s1_q, io_s2_q;
    logic        rb_s1_q, rb_s2_q;
    logic        id_we;
    logic [2:0]  id_ra_q, id_ra_d;
    logic [7:0]  id_rd;
    logic [2:0]  id_rp;
    logic [31:0] id_lo_q, id_lo_d;
    logic [7:0]  id_hi_q, id_hi_d;

    // First command byte of an operation
    function automatic logic [7:0] first_cmd(input logic [3:0] op);
        case (op)
            NSC_OP_RESET:   first_cmd = NSC_CMD_RESET;
            NSC_OP_STATUS:  first_cmd = NSC_CMD_STATUS;
            NSC_OP_STAT_EN: first_cmd = NSC_CMD_STAT_EN;
            NSC_OP_READ_ID: first_cmd = NSC_CMD_READ_ID;
            default:        first_cmd = NSC_CMD_READ;
        endcase
    endfunction

    nsc_idmem #(.DEPTH(8)) u_idmem (
        .i_clock   (i_clock),
        .i_sys_rst (i_sys_rst),
        .i_we      (id_we),
        .i_waddr   (rc_q),
        .i_wdata   (io_s2_q),
        .i_raddr   (id_ra_q),
        .o_rdata   (id_rd)
    );

    // Address whose word the memory presents now
    assign id_rp = id_ra_q - 3'd1;

    // Pin synchronisers
    always_ff @(posedge i_clock) begin
        io_s1_q <= i_nand_io;
        io_s2_q <= io_s1_q;
        rb_s1_q <= i_nand_rb_n;
        rb_s2_q <= rb_s1_q;
    end

    always_comb begin
        st_d = st_q; op_d = op_q; na_d = na_q; ai_d = ai_q; addr_d = addr_q; rc_d = rc_q;
        ph_d = ph_q; hi_d = hi_q; rstd_d = rstd_q; idm_d = idm_q; busy_d = busy_q; opst_d = opst_q;
        ce_n_d = ce_n_q; cle_d = cle_q; ale_d = ale_q; we_n_d = we_n_q; re_n_d = re_n_q;
        io_d = io_q; oe_d = oe_q; prdata_d = prdata_q; pready_d = 1'b0; perr_d = 1'b0;
        id_we = 1'b0; id_ra_d = id_ra_q; id_lo_d = id_lo_q; id_hi_d = id_hi_q;
        // APB access answers one cycle after setup
        if (i_psel && !i_penable) begin
            pready_d = 1'b1;
            if (i_pwrite) begin
                if (i_paddr == NSC_CTRL_OFF) begin
                    if (i_pwdata[NSC_CTRL_GO_BIT] && st_q == NSC_IDLE) begin
                        op_d = i_pwdata[NSC_CTRL_OP_LSB +: 4];
                        na_d = i_pwdata[NSC_CTRL_NA_LSB +: 3];
                        // Reset-first, status-after-ID and busy gating enforced here
                        if (!rstd_q && i_pwdata[NSC_CTRL_OP_LSB +: 4] != NSC_OP_RESET) begin
                            perr_d = 1'b1;
                        end else if (idm_q && i_pwdata[NSC_CTRL_OP_LSB +: 4] == NSC_OP_STATUS) begin
                            perr_d = 1'b1;
                        end else if (busy_q && i_pwdata[NSC_CTRL_OP_LSB +: 4] > NSC_OP_STAT_EN) begin
                            perr_d = 1'b1;
                        end else begin
                            st_d = NSC_CMD; ph_d = 8'h00; hi_d = 1'b0; ai_d = 3'h0; rc_d = 3'h0;
                        end
                    end else if (i_pwdata[NSC_CTRL_GO_BIT]) begin
                        perr_d = 1'b1;
                    end
                end else if (i_paddr == NSC_ADDR_OFF) begin
                    addr_d = {8'h00, i_pwdata};
                end else begin
                    perr_d = 1'b1;
                end
            end else begin
                if (i_paddr == NSC_STAT_OFF) begin
                    prdata_d = {20'h0, idm_q, rstd_q, rb_s2_q, st_q == NSC_IDLE, opst_q};
                end else if (i_paddr == NSC_ADDR_OFF) begin
                    prdata_d = addr_q[31:0];
                end else if (i_paddr == NSC_ID_LO_OFF) begin
                    prdata_d = id_lo_q;
                end else if (i_paddr == NSC_ID_HI_OFF) begin
                    prdata_d = {24'h0, id_hi_q};
                end else if (i_paddr == NSC_RDATA_OFF) begin
                    prdata_d = {24'h0, opst_q};
                end else begin
                    prdata_d = 32'h0; perr_d = 1'b1;
                end
            end
        end
        // Status byte copied from the bus in status mode only while re_n_q is low in NSC_IDLE; re_n_q is always high there
        if ((op_q == NSC_OP_STATUS || op_q == NSC_OP_STAT_EN) && !re_n_q && st_q == NSC_IDLE) begin
            opst_d = io_s2_q;
        end
        // ID bytes collected into registers
        id_ra_d = id_ra_q + 3'd1;
        if (id_rp < 3'd4) begin
            id_lo_d[id_rp[1:0]*8 +: 8] = id_rd;
        end else if (id_rp == 3'd4) begin
            id_hi_d = id_rd;
        end
        ph_d = ph_q + 8'd1;
        case (st_q)
            NSC_IDLE: begin
                ph_d = 8'h00;
            end
            NSC_CMD: begin
                ce_n_d = 1'b0; cle_d = 1'b1; ale_d = 1'b0; oe_d = 1'b1; io_d = first_cmd(op_q);
                we_n_d = ph_q < 8'(NSC_PULSE_CYC);
                we_n_d = !we_n_d;
                if (ph_q == 8'(2 * NSC_PULSE_CYC)) begin
                    cle_d = 1'b0; ph_d = 8'h00;
                    if (op_q == NSC_OP_RESET) begin
                        // Busy flag marks the reset wait; any order during it, a second reset included, is refused because st_q is not NSC_IDLE
                        rstd_d = 1'b1; idm_d = 1'b0; busy_d = 1'b1; st_d = NSC_WAIT;
                    end else if (op_q == NSC_OP_READ_ID) begin
                        idm_d = 1'b1; na_d = 3'd1; addr_d = {32'h0, NSC_ID_ADDR}; st_d = NSC_ADR;
                    end else if (op_q == NSC_OP_STAT_EN || op_q >= NSC_OP_CB_READ) begin
                        idm_d = 1'b0; st_d = NSC_ADR;
                    end else begin
                        // 70h leaves status mode sticky at the device; plain 00h ends it
                        idm_d = 1'b0; st_d = (op_q == NSC_OP_STATUS) ? NSC_RD : NSC_DONE;
                    end
                end
            end
            NSC_ADR: begin
                cle_d = 1'b0; ale_d = 1'b1; oe_d = 1'b1; io_d = addr_q[ai_q*8 +: 8];
                we_n_d = !(ph_q < 8'(NSC_PULSE_CYC));
                if (ph_q == 8'(2 * NSC_PULSE_CYC)) begin
                    ph_d = 8'h00; ai_d = ai_q + 3'd1;
                    if (ai_q + 3'd1 >= na_q || ai_q + 3'd1 == 3'(NSC_ADDR_MAX)) begin
                        ale_d = 1'b0;
                        st_d = (op_q >= NSC_OP_CB_READ) ? NSC_CMD2 : NSC_RD;
                    end
                end
            end
            NSC_CMD2: begin
                cle_d = 1'b1; oe_d = 1'b1;
                io_d = (op_q == NSC_OP_CB_SPEC) ? NSC_CMD_CB_SPEC : NSC_CMD_CB_CONF;
                we_n_d = !(ph_q < 8'(NSC_PULSE_CYC));
                if (ph_q == 8'(2 * NSC_PULSE_CYC)) begin
                    cle_d = 1'b0; ph_d = 8'h00; busy_d = 1'b1; st_d = NSC_WAIT;
                end
            end
            NSC_WAIT: begin
                oe_d = 1'b0;
                // Ready/busy pin low then high ends the wait
                if (!rb_s2_q) begin
                    hi_d = 1'b1;
                end
                if (hi_q && rb_s2_q) begin
                    busy_d = 1'b0; st_d = NSC_DONE;
                end
            end
            NSC_RD: begin
                oe_d = 1'b0; cle_d = 1'b0; ale_d = 1'b0;
                re_n_d = !(ph_q < 8'(NSC_PULSE_CYC));
                if (ph_q == 8'(NSC_PULSE_CYC + 2)) begin
                    if (op_q == NSC_OP_READ_ID) begin
                        id_we = 1'b1; id_ra_d = 3'h0;
                    end else begin
                        opst_d = io_s2_q;
                    end
                end
                if (ph_q == 8'(2 * NSC_PULSE_CYC + 2)) begin
                    ph_d = 8'h00; rc_d = rc_q + 3'd1;
                    if (op_q != NSC_OP_READ_ID || rc_q + 3'd1 == 3'(NSC_ID_BYTES)) begin
                        st_d = NSC_DONE;
                    end
                end
            end
            default: begin
                re_n_d = 1'b1; we_n_d = 1'b1; oe_d = 1'b0; ce_n_d = 1'b1; st_d = NSC_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            st_q <= NSC_IDLE; op_q <= 4'h0; na_q <= 3'h0; ai_q <= 3'h0; addr_q <= 40'h0; rc_q <= 3'h0;
            ph_q <= 8'h00; hi_q <= 1'b0; rstd_q <= 1'b0; idm_q <= 1'b0; busy_q <= 1'b0;
            opst_q <= NSC_OPST_RST; ce_n_q <= 1'b1; cle_q <= 1'b0; ale_q <= 1'b0; we_n_q <= 1'b1;
            re_n_q <= 1'b1; io_q <= 8'h00; oe_q <= 1'b0; prdata_q <= 32'h0; pready_q <= 1'b0;
            perr_q <= 1'b0; id_ra_q <= 3'h7; id_lo_q <= 32'h0; id_hi_q <= 8'h00;
        end else begin
            st_q <= st_d; op_q <= op_d; na_q <= na_d; ai_q <= ai_d; addr_q <= addr_d; rc_q <= rc_d;
            ph_q <= ph_d; hi_q <= hi_d; rstd_q <= rstd_d; idm_q <= idm_d; busy_q <= busy_d;
            opst_q <= opst_d; ce_n_q <= ce_n_d; cle_q <= cle_d; ale_q <= ale_d; we_n_q <= we_n_d;
            re_n_q <= re_n_d; io_q <= io_d; oe_q <= oe_d; prdata_q <= prdata_d; pready_q <= pready_d;
            perr_q <= perr_d; id_ra_q <= id_ra_d; id_lo_q <= id_lo_d; id_hi_q <= id_hi_d;
        end
    end

    assign o_prdata    = prdata_q;
    assign o_pready    = pready_q;
    assign o_pslverr   = perr_q;
    assign o_nand_ce_n = ce_n_q;
    assign o_nand_cle  = cle_q;
    assign o_nand_ale  = ale_q;
    assign o_nand_we_n = we_n_q;
    assign o_nand_re_n = re_n_q;
    assign o_nand_io   = io_q;
    assign o_nand_io_oe = oe_q;
endmodule

/* File: test/nsc_host_props.sv */
// Port checker for the NAND host controller.
// Assumes it is bound into nsc_host and sees its ports by name.
`timescale 1ns/100ps
module nsc_host_props (
    // Clock, reset, APB
    input wire logic       i_clock,
    input wire logic       i_sys_rst,
    input wire logic       i_psel,
    input wire logic       i_penable,
    input wire logic       o_pready,
    input wire logic       o_pslverr,
    // NAND pins
    input wire logic       o_nand_ce_n,
    input wire logic       o_nand_cle,
    input wire logic       o_nand_ale,
    input wire logic       o_nand_we_n,
    input wire logic       o_nand_re_n,
    input wire logic [7:0] o_nand_io,
    input wire logic       o_nand_io_oe
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_sys_rst);
    property p_answer; i_psel && !i_penable |=> o_pready; endproperty
    a_answer: assert property (p_answer) else $error("no answer after setup");
    property p_pulse; o_pready |=> !o_pready; endproperty
    a_pulse: assert property (p_pulse) else $error("ready longer than one cycle");
    property p_err; o_pslverr |-> o_pready; endproperty
    a_err: assert property (p_err) else $error("error without ready");
    property p_idle; $past(i_sys_rst) |-> o_nand_ce_n && o_nand_we_n && o_nand_re_n && !o_nand_io_oe; endproperty
    a_idle: assert property (p_idle) else $error("pins not idle after reset");
    property p_we_width; $fell(o_nand_we_n) |=> !o_nand_we_n ##1 o_nand_we_n; endproperty
    a_we_width: assert property (p_we_width) else $error("write strobe width wrong");
    property p_we_ce; !o_nand_we_n |-> !o_nand_ce_n && o_nand_io_oe && !(o_nand_cle && o_nand_ale); endproperty
    a_we_ce: assert property (p_we_ce) else $error("write strobe without select or drive");
    property p_read_free; !o_nand_re_n |-> !o_nand_io_oe && !o_nand_ce_n; endproperty
    a_read_free: assert property (p_read_free) else $error("host drives bus while reading");
    property p_rst_wait; o_nand_cle && !o_nand_we_n && o_nand_io == 8'hFF |=> !o_nand_ce_n [*4]; endproperty
    a_rst_wait: assert property (p_rst_wait) else $error("reset not waited out");
    c_reset: cover property (o_nand_cle && !o_nand_we_n && o_nand_io == 8'hFF);
    c_read: cover property ($fell(o_nand_re_n));
    c_refuse: cover property (o_pslverr);
endmodule

/* File: test/nsc_nand_model.sv */
// Behavioural NAND device for reset, status, ID and copy-back reads.
// Assumes the host keeps pin timing; the device has no clock.
`timescale 1ns/100ps
module nsc_nand_model #(
    parameter int          T_RST_NS = 2000,
    parameter int          T_CB_NS  = 1000,
    parameter logic [39:0] ID_BYTES = 40'h0
) (
    // Pins from the host, bus level, and i_wp_n from the testbench
    input  wire logic       i_ce_n,
    input  wire logic       i_cle,
    input  wire logic       i_ale,
    input  wire logic       i_we_n,
    input  wire logic       i_re_n,
    input  wire logic [7:0] i_io,
    input  wire logic       i_wp_n,
    // Pins to the host
    output logic      [7:0] o_io,
    output logic            o_rb_n
);
    logic [1:0] mode_q = 2'h0;
    logic [2:0] rdc_q  = 3'h0;
    logic [2:0] base_q = 3'h0;
    logic [2:0] nadr_q = 3'h0;
    logic [7:0] conf_q = 8'h00;
    logic       rb_q   = 1'b1;
    logic [2:0] idx_q;
    logic [7:0] val;
    // Reads counted since the last command
    assign idx_q  = rdc_q - base_q;
    assign o_rb_n = rb_q;
    // Live status: protect, ready, array idle, rest cleared by reset
    assign val  = (mode_q == 2'h3) ? ID_BYTES[idx_q*8 +: 8] : {i_wp_n, o_rb_n, o_rb_n, 5'h00};
    assign o_io = (!i_ce_n && !i_re_n && mode_q != 2'h0) ? val : ~val;
    // Busy periods block this process, so commands are ignored meanwhile
    always @(posedge i_we_n) begin
        if (!i_ce_n && i_ale) nadr_q = nadr_q + 3'h1;
        if (!i_ce_n && i_cle) begin
            mode_q = 2'h0;
            nadr_q = 3'h0;
            base_q = rdc_q;
            case (i_io)
                8'hFF: begin
                    rb_q = 1'b0;
                    #(T_RST_NS);
                    rb_q = 1'b1;
                end
                8'h70, 8'h78: mode_q = 2'h1;
                8'h90: mode_q = 2'h3;
                8'h35, 8'h36: begin
                    conf_q = i_io;
                    rb_q = 1'b0;
                    #(T_CB_NS);
                    rb_q = 1'b1;
                end
                default: ;
            endcase
        end
    end
    // Next ID byte on each read cycle
    always @(posedge i_re_n) begin
        if (!i_ce_n) rdc_q = rdc_q + 3'h1;
    end
endmodule

/* File: test/nand_status_reset_id_cmds_test.sv */
// Testbench: APB orders to the host controller, behavioural device on the pins.
// Assumes nsc_pkg, nsc_host, nsc_host_props and nsc_nand_model.
`timescale 1ns/100ps
module nand_status_reset_id_cmds_test;
    import nsc_pkg::*;
    // Identification bytes: arbitrary values
    localparam logic [39:0] IDS = 40'h42_15_00_C5_3A;
    logic        i_clock   = 1'b0;
    logic        i_sys_rst = 1'b1;
    logic        psel      = 1'b0;
    logic        penable   = 1'b0;
    logic        pwrite    = 1'b0;
    logic        wp_n      = 1'b1;
    logic [7:0]  paddr     = 8'h00;
    logic [31:0] pwdata    = 32'h0;
    logic [31:0] prdata, rd;
    logic        pready, pslverr, slv, ce_n, cle, ale, we_n, re_n, oe, rb_n;
    logic [7:0]  io_o, dev_o, bus;
    int          n_errors    = 0;
    int          comparisons = 0;
    assign bus = oe ? io_o : dev_o;
    nsc_host dut (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
        .o_pslverr(pslverr), .o_nand_ce_n(ce_n), .o_nand_cle(cle), .o_nand_ale(ale), .o_nand_we_n(we_n),
        .o_nand_re_n(re_n), .o_nand_io(io_o), .o_nand_io_oe(oe), .i_nand_io(bus), .i_nand_rb_n(rb_n));
    nsc_nand_model #(.ID_BYTES(IDS)) u_nand (.i_ce_n(ce_n), .i_cle(cle), .i_ale(ale), .i_we_n(we_n),
        .i_re_n(re_n), .i_io(bus), .i_wp_n(wp_n), .o_io(dev_o), .o_rb_n(rb_n));
    initial begin
        forever #10 i_clock = ~i_clock;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clock);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge i_clock);
        penable <= 1'b1;
        do @(posedge i_clock); while (pready !== 1'b1);
        rd = prdata;
        slv = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic op(input logic [3:0] o, input logic [2:0] n, input logic e);
        apb(1'b1, NSC_CTRL_OFF, {23'h0, 1'b1, 1'b0, n, o});
        chk({31'h0, slv}, {31'h0, e});
        do apb(1'b0, NSC_STAT_OFF, 32'h0); while (rd[8] !== 1'b1);
    endtask
    task automatic status(input logic [7:0] exp);
        op(NSC_OP_STATUS, 3'h0, 1'b0);
        apb(1'b0, NSC_RDATA_OFF, 32'h0);
        chk({24'h0, rd[7:0]}, {24'h0, exp});
    endtask
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        repeat (40000) @(posedge i_clock);
        n_errors++;
        conclude;
    end
    initial begin
        repeat (10) @(posedge i_clock);
        i_sys_rst <= 1'b0;
        op(NSC_OP_STATUS, 3'h0, 1'b1);
        $display("test refusal before reset done");
        for (int k = 1; k >= 0; k--) begin
            wp_n <= k[0];
            op(NSC_OP_RESET, 3'h0, 1'b0);
            status(k[0] ? NSC_OPST_RST : 8'h60);
        end
        wp_n <= 1'b1;
        $display("test reset and status done");
        apb(1'b1, NSC_ADDR_OFF, 32'h0);
        op(NSC_OP_READ_ID, 3'h1, 1'b0);
        apb(1'b0, NSC_ID_LO_OFF, 32'h0);
        chk(rd, IDS[31:0]);
        apb(1'b0, NSC_ID_HI_OFF, 32'h0);
        chk({24'h0, rd[7:0]}, {24'h0, IDS[39:32]});
        op(NSC_OP_STATUS, 3'h0, 1'b1);
        op(NSC_OP_RD_MODE, 3'h0, 1'b0);
        status(NSC_OPST_RST);
        $display("test identification done");
        apb(1'b1, NSC_ADDR_OFF, 32'h0000_0201);
        op(NSC_OP_STAT_EN, 3'h3, 1'b0);
        chk({29'h0, u_nand.nadr_q}, 32'h0000_0003);
        apb(1'b0, NSC_RDATA_OFF, 32'h0);
        chk({24'h0, rd[7:0]}, 32'h0000_00E0);
        $display("test enhanced status done");
        for (int k = 0; k < 2; k++) begin
            apb(1'b1, NSC_ADDR_OFF, 32'h0403_0201);
            op(k[0] ? NSC_OP_CB_SPEC : NSC_OP_CB_READ, 3'h4, 1'b0);
            chk({24'h0, u_nand.conf_q}, k[0] ? 32'h0000_0036 : 32'h0000_0035);
        end
        $display("test copy-back read done");
        apb(1'b0, NSC_ADDR_OFF, 32'h0);
        chk(rd, 32'h0403_0201);
        apb(1'b1, NSC_CTRL_OFF, 32'h0000_0100);
        chk({31'h0, slv}, 32'h0000_0000);
        apb(1'b1, NSC_CTRL_OFF, 32'h0000_0100);
        chk({31'h0, slv}, 32'h0000_0001);
        do apb(1'b0, NSC_STAT_OFF, 32'h0); while (rd[8] !== 1'b1);
        status(NSC_OPST_RST);
        $display("test readback and busy refusal done");
        apb(1'b0, 8'h20, 32'h0);
        chk({31'h0, slv}, 32'h0000_0001);
        $display("test unmapped address done");
        conclude;
    end
endmodule
bind nsc_host nsc_host_props u_props (.*);
